// ===== hdl/duart_bus_select_rs485_dir.sv
// Top of the dual UART bus style select and RS-485 direction logic.
`timescale 1ns/10ps
`include "duart_dir_consts.svh"
module duart_bus_select_rs485_dir (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reset_pin,
    input wire logic bus_style_strap,
    input wire logic prescaler_strap,
    input wire logic half_duplex_strap_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic channel_address_bit,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire duart_pkg::chan_in_t chan_a_in,
    input wire duart_pkg::chan_in_t chan_b_in,
    output logic [7:0] host_rdata_q,
    output logic host_rdata_oe_q,
    output duart_pkg::chan_out_t chan_a_out_q,
    output duart_pkg::chan_out_t chan_b_out_q,
    output logic strobe_style_q,
    output logic auto_dir_strap_q
);
    logic dev_rst;
    logic reset_active;
    logic strobe_style_d;
    logic auto_dir_strap_d;
    logic div4_strap_q;
    logic div4_strap_d;
    logic rd_n_q;
    logic wr_n_q;
    logic csa_n_q;
    logic csb_n_q;
    logic addr_bit_q;
    logic [2:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] host_rdata_d;
    logic host_rdata_oe_d;
    logic wr_a;
    logic wr_b;
    logic rd_start;
    logic rd_a;
    logic rd_b;
    logic [7:0] mcr_a;
    logic [7:0] feature_control_reg_a;
    logic [7:0] extended_modem_status_reg_a;
    logic [7:0] mcr_b;
    logic [7:0] feature_control_reg_b;
    logic [7:0] extended_modem_status_reg_b;

    // Readback of one channel's register at a given address.
    function automatic logic [7:0] reg_mux(
        input logic [2:0] addr,
        input logic [7:0] modem_control_reg,
        input logic [7:0] feature_control_reg,
        input logic [7:0] extended_modem_status_reg
    );
        logic [7:0] val;
        val = 8'h00;
        case (addr)
            `MCR_ADDR: val = modem_control_reg;
            `FEATURE_CONTROL_REG_ADDR: val = feature_control_reg;
            `EXTENDED_MODEM_STATUS_REG_ADDR: val = extended_modem_status_reg;
            default: val = 8'h00;
        endcase
        return val;
    endfunction : reg_mux

    // The polarity follows the live strap, since the latched copy is itself
    // reloaded from the strap during this reset.
    assign reset_active = bus_style_strap ? reset_pin : ~reset_pin;
    assign dev_rst = ~rst_b | reset_active;

    // Straps are followed during reset and frozen at its release.
    always_comb begin
        strobe_style_d = strobe_style_q;
        auto_dir_strap_d = auto_dir_strap_q;
        div4_strap_d = div4_strap_q;
        if (dev_rst) begin
            strobe_style_d = bus_style_strap;
            auto_dir_strap_d = ~half_duplex_strap_n;
            div4_strap_d = ~prescaler_strap;
        end
    end

    always_ff @(posedge core_clk) begin
        strobe_style_q <= strobe_style_d;
        auto_dir_strap_q <= auto_dir_strap_d;
        div4_strap_q <= div4_strap_d;
    end

    // Bus cycles are decoded from the previous sample and the current one,
    // so a strobe must stay low across at least one rising clock edge.
    always_comb begin
        wr_a = 1'b0;
        wr_b = 1'b0;
        rd_start = 1'b0;
        rd_a = 1'b0;
        rd_b = 1'b0;
        host_rdata_oe_d = 1'b0;
        if (strobe_style_q) begin
            // Both selects low is a broadcast write; a read then returns 0.
            wr_a = !wr_n_q && write_strobe_n && !csa_n_q;
            wr_b = !wr_n_q && write_strobe_n && !csb_n_q;
            rd_start = rd_n_q && !read_strobe_n;
            rd_a = !chan_a_select_n && chan_b_select_n;
            rd_b = chan_a_select_n && !chan_b_select_n;
            host_rdata_oe_d = !read_strobe_n &&
                (!chan_a_select_n || !chan_b_select_n);
        end else begin
            // Select line is chan_a_select_n, read-not-write is read_strobe_n.
            wr_a = !csa_n_q && chan_a_select_n && !rd_n_q &&
                !addr_bit_q;
            wr_b = !csa_n_q && chan_a_select_n && !rd_n_q && addr_bit_q;
            rd_start = csa_n_q && !chan_a_select_n && read_strobe_n;
            rd_a = !channel_address_bit;
            rd_b = channel_address_bit;
            host_rdata_oe_d = !chan_a_select_n && read_strobe_n;
        end
    end

    always_comb begin
        host_rdata_d = host_rdata_q;
        if (rd_start) begin
            host_rdata_d = rd_a ? reg_mux(host_addr, mcr_a, feature_control_reg_a, extended_modem_status_reg_a) :
                rd_b ? reg_mux(host_addr, mcr_b, feature_control_reg_b, extended_modem_status_reg_b) : 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            csa_n_q <= 1'b1;
            csb_n_q <= 1'b1;
            addr_bit_q <= 1'b0;
            addr_q <= 3'h0;
            wdata_q <= 8'h00;
            host_rdata_q <= 8'h00;
            host_rdata_oe_q <= 1'b0;
        end else begin
            rd_n_q <= read_strobe_n;
            wr_n_q <= write_strobe_n;
            csa_n_q <= chan_a_select_n;
            csb_n_q <= chan_b_select_n;
            addr_bit_q <= channel_address_bit;
            addr_q <= host_addr;
            wdata_q <= host_wdata;
            host_rdata_q <= host_rdata_d;
            host_rdata_oe_q <= host_rdata_oe_d;
        end
    end

    chan_dir u_chan_a (
        .core_clk(core_clk),
        .dev_rst(dev_rst),
        .strap_div4(div4_strap_q),
        .strap_auto(auto_dir_strap_q),
        .wr_en(wr_a),
        .wr_addr(addr_q),
        .wr_data(wdata_q),
        .chan_in(chan_a_in),
        .chan_out_q(chan_a_out_q),
        .mcr_q(mcr_a),
        .feature_control_reg_q(feature_control_reg_a),
        .extended_modem_status_reg_q(extended_modem_status_reg_a)
    );

    chan_dir u_chan_b (
        .core_clk(core_clk),
        .dev_rst(dev_rst),
        .strap_div4(div4_strap_q),
        .strap_auto(auto_dir_strap_q),
        .wr_en(wr_b),
        .wr_addr(addr_q),
        .wr_data(wdata_q),
        .chan_in(chan_b_in),
        .chan_out_q(chan_b_out_q),
        .mcr_q(mcr_b),
        .feature_control_reg_q(feature_control_reg_b),
        .extended_modem_status_reg_q(extended_modem_status_reg_b)
    );
endmodule : duart_bus_select_rs485_dir

// ===== hdl/duart_dir_consts.svh
// Constants for the dual UART bus select and RS-485 direction block.
`ifndef DUART_DIR_CONSTS_SVH
`define DUART_DIR_CONSTS_SVH

`define MCR_ADDR 3'h4
`define FEATURE_CONTROL_REG_ADDR 3'h5
`define EXTENDED_MODEM_STATUS_REG_ADDR 3'h6
`define MCR_RESET 8'h00
`define FEATURE_CONTROL_REG_RESET 8'h00
`define EXTENDED_MODEM_STATUS_REG_RESET 8'h00
`define MCR_RTS_BIT 1
`define MCR_PRESCALE_BIT 7
`define EXTENDED_MODEM_STATUS_REG_INVERT_BIT 3
`define FEATURE_CONTROL_REG_AUTO_DIR_BIT 3
`define FEATURE_CONTROL_REG_SAMPLE_8X_BIT 6
`define TX_FIFO_DEPTH 64
`define RX_FIFO_DEPTH 64

`endif

// ===== hdl/duart_pkg.sv
// Types shared by the dual UART direction block and its channel slice.
package duart_pkg;
    typedef struct packed {
        logic tx_load;
        logic tx_fifo_empty;
        logic tx_shift_empty;
        logic tx_bit;
        logic rx_bit;
    } chan_in_t;

    typedef struct packed {
        logic tx_serial;
        logic rts_n;
        logic prescale_div4;
        logic sample_8x;
        logic rx_bit;
    } chan_out_t;

    typedef enum logic [1:0] {
        DIR_RECEIVE = 2'b01,
        DIR_TRANSMIT = 2'b10
    } dir_state_t;
endpackage : duart_pkg

// ===== hdl/chan_dir.sv
// One channel's configuration registers and RS-485 direction control.
`timescale 1ns/10ps
`include "duart_dir_consts.svh"
module chan_dir (
    input wire logic core_clk,
    input wire logic dev_rst,
    input wire logic strap_div4,
    input wire logic strap_auto,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire duart_pkg::chan_in_t chan_in,
    output duart_pkg::chan_out_t chan_out_q,
    output logic [7:0] mcr_q,
    output logic [7:0] feature_control_reg_q,
    output logic [7:0] extended_modem_status_reg_q
);
    logic [7:0] mcr_d;
    logic [7:0] feature_control_reg_d;
    logic [7:0] extended_modem_status_reg_d;
    logic mcr_written_q;
    logic mcr_written_d;
    duart_pkg::dir_state_t dir_q;
    duart_pkg::dir_state_t dir_d;
    duart_pkg::chan_out_t chan_out_d;
    logic auto_on;
    logic dir_level;

    always_comb begin
        mcr_d = mcr_q;
        feature_control_reg_d = feature_control_reg_q;
        extended_modem_status_reg_d = extended_modem_status_reg_q;
        mcr_written_d = mcr_written_q;
        if (wr_en) begin
            case (wr_addr)
                `MCR_ADDR: begin
                    mcr_d = wr_data;
                    mcr_written_d = 1'b1;
                end
                `FEATURE_CONTROL_REG_ADDR: begin
                    feature_control_reg_d = wr_data;
                end
                `EXTENDED_MODEM_STATUS_REG_ADDR: begin
                    extended_modem_status_reg_d = wr_data;
                end
                default: begin
                    mcr_d = mcr_q;
                end
            endcase
        end
    end

    // A load in the same cycle as the drain keeps the line in transmit.
    always_comb begin
        dir_d = dir_q;
        case (dir_q)
            duart_pkg::DIR_RECEIVE: begin
                if (chan_in.tx_load) begin
                    dir_d = duart_pkg::DIR_TRANSMIT;
                end
            end
            duart_pkg::DIR_TRANSMIT: begin
                if (!chan_in.tx_load && chan_in.tx_fifo_empty &&
                    chan_in.tx_shift_empty) begin
                    dir_d = duart_pkg::DIR_RECEIVE;
                end
            end
            default: begin
                dir_d = duart_pkg::DIR_RECEIVE;
            end
        endcase
    end

    // The strap forces automatic mode; the register bit only counts when
    // the strap is low.
    assign auto_on = strap_auto | feature_control_reg_q[`FEATURE_CONTROL_REG_AUTO_DIR_BIT];
    assign dir_level = (dir_q == duart_pkg::DIR_RECEIVE) ^
        extended_modem_status_reg_q[`EXTENDED_MODEM_STATUS_REG_INVERT_BIT];

    always_comb begin
        chan_out_d.tx_serial = chan_in.tx_bit;
        chan_out_d.rx_bit = chan_in.rx_bit;
        chan_out_d.rts_n = auto_on ? dir_level : ~mcr_q[`MCR_RTS_BIT];
        chan_out_d.prescale_div4 = mcr_written_q ?
            mcr_q[`MCR_PRESCALE_BIT] : strap_div4;
        chan_out_d.sample_8x = feature_control_reg_q[`FEATURE_CONTROL_REG_SAMPLE_8X_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            mcr_q <= `MCR_RESET;
            feature_control_reg_q <= `FEATURE_CONTROL_REG_RESET;
            extended_modem_status_reg_q <= `EXTENDED_MODEM_STATUS_REG_RESET;
            mcr_written_q <= 1'b0;
            dir_q <= duart_pkg::DIR_RECEIVE;
            chan_out_q.tx_serial <= 1'b1;
            chan_out_q.rx_bit <= 1'b1;
            chan_out_q.rts_n <= 1'b1;
            chan_out_q.prescale_div4 <= 1'b0;
            chan_out_q.sample_8x <= 1'b0;
        end else begin
            mcr_q <= mcr_d;
            feature_control_reg_q <= feature_control_reg_d;
            extended_modem_status_reg_q <= extended_modem_status_reg_d;
            mcr_written_q <= mcr_written_d;
            dir_q <= dir_d;
            chan_out_q <= chan_out_d;
        end
    end
endmodule : chan_dir

// ===== sim/duart_dir_properties.sv
// Concurrent checks on the ports of the direction block's top module.
`timescale 1ns/10ps
module duart_dir_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reset_pin,
    input wire logic bus_style_strap,
    input wire logic prescaler_strap,
    input wire logic half_duplex_strap_n,
    input wire duart_pkg::chan_in_t chan_a_in,
    input wire logic [7:0] host_rdata_q,
    input wire logic host_rdata_oe_q,
    input wire duart_pkg::chan_out_t chan_a_out_q,
    input wire logic strobe_style_q,
    input wire logic auto_dir_strap_q
);
    // The pin's active level follows the live style strap, not the latch.
    logic dev_rst;
    assign dev_rst = !rst_b || (reset_pin == bus_style_strap);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    line_idle_a: assert property (
        dev_rst |=> chan_a_out_q.tx_serial && chan_a_out_q.rts_n)
        else $error("line outputs not idle after reset");
    rx_ignore_a: assert property (
        dev_rst |=> chan_a_out_q.rx_bit)
        else $error("receive input not ignored in reset");
    rx_follow_a: assert property (
        !dev_rst |=> chan_a_out_q.rx_bit == $past(chan_a_in.rx_bit))
        else $error("receive input does not follow");
    tx_follow_a: assert property (
        !dev_rst |=> chan_a_out_q.tx_serial == $past(chan_a_in.tx_bit))
        else $error("transmit output does not follow");
    read_idle_a: assert property (
        dev_rst |=> !host_rdata_oe_q && host_rdata_q == 8'h00)
        else $error("read side not cleared by reset");
    style_latch_a: assert property (
        dev_rst |=> strobe_style_q == $past(bus_style_strap))
        else $error("bus style not latched in reset");
    auto_latch_a: assert property (
        dev_rst |=> auto_dir_strap_q == !$past(half_duplex_strap_n))
        else $error("direction strap not latched in reset");
    strap_hold_a: assert property (
        !dev_rst |=> $stable(strobe_style_q) && $stable(auto_dir_strap_q))
        else $error("latched strap moved outside reset");
    presc_strap_a: assert property (
        dev_rst ##1 !dev_rst |=>
            chan_a_out_q.prescale_div4 == !$past(prescaler_strap, 2))
        else $error("prescaler does not follow strap");
endmodule : duart_dir_checker
bind duart_bus_select_rs485_dir duart_dir_checker duart_dir_checker_i (
    .core_clk(core_clk), .rst_b(rst_b), .reset_pin(reset_pin),
    .bus_style_strap(bus_style_strap), .prescaler_strap(prescaler_strap),
    .half_duplex_strap_n(half_duplex_strap_n), .chan_a_in(chan_a_in),
    .host_rdata_q(host_rdata_q), .host_rdata_oe_q(host_rdata_oe_q),
    .chan_a_out_q(chan_a_out_q), .strobe_style_q(strobe_style_q),
    .auto_dir_strap_q(auto_dir_strap_q));

// ===== sim/tx_source.sv
// Transmit-side source: pulses a load, then drains FIFO and shifter.
`timescale 1ns/10ps
module tx_source #(
    parameter int DRAIN = 12
) (
    input wire logic core_clk,
    input wire logic start,
    output duart_pkg::chan_in_t ci
);
    int cnt = 0;
    initial ci = 5'h0f;
    // The FIFO empties two cycles before the shifter, so a switch made on
    // the FIFO flag alone shows up early.
    always @(posedge core_clk) begin
        ci.tx_load <= start;
        ci.tx_fifo_empty <= !start && cnt < 4;
        ci.tx_shift_empty <= !start && cnt < 2;
        ci.tx_bit <= cnt == 0 || cnt[0];
        // The receive line rests low, so a reset that fails to gate it
        // shows on the channel output.
        ci.rx_bit <= cnt[1];
        cnt <= start ? DRAIN : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule : tx_source

// ===== sim/tb.sv
// Self-checking bench for the bus select and direction block.
`timescale 1ns/10ps
module tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rpin = 1'b0;
    logic sty = 1'b1;
    logic presc = 1'b0;
    logic hd_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic csa_n = 1'b1;
    logic csb_n = 1'b1;
    logic cab = 1'b0;
    logic go = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic oe, sty_q, auto_q, oe_seen;
    logic [7:0] rdata, q;
    duart_pkg::chan_in_t ci;
    duart_pkg::chan_out_t ao, bo;
    int err_count = 0;
    int n_checks = 0;
    always #5 core_clk = !core_clk;
    tx_source tx_source_i (.core_clk(core_clk), .start(go), .ci(ci));
    duart_bus_select_rs485_dir duart_bus_select_rs485_dir_i (
        .core_clk(core_clk), .rst_b(rst_b), .reset_pin(rpin),
        .bus_style_strap(sty), .prescaler_strap(presc),
        .half_duplex_strap_n(hd_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .chan_a_select_n(csa_n),
        .chan_b_select_n(csb_n), .channel_address_bit(cab),
        .host_addr(addr), .host_wdata(wdata), .chan_a_in(ci),
        .chan_b_in(ci), .host_rdata_q(rdata), .host_rdata_oe_q(oe),
        .chan_a_out_q(ao), .chan_b_out_q(bo), .strobe_style_q(sty_q),
        .auto_dir_strap_q(auto_q));
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // Channel code: 0 is A, 1 is B, 2 is both (strobe style only).
    task automatic xfer(input logic rd, input logic [1:0] ch,
        input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        wdata = d;
        if (sty) begin
            csa_n = ch == 2'h1;
            csb_n = ch == 2'h0;
            rd_n = !rd;
            wr_n = rd;
        end else begin
            rd_n = rd;
            cab = ch[0];
            csa_n = 1'b0;
        end
        repeat (2) @(negedge core_clk);
        q = rdata;
        oe_seen = oe;
        rd_n = sty;
        wr_n = 1'b1;
        csa_n = 1'b1;
        @(negedge core_clk);
        rd_n = 1'b1;
        csb_n = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask : xfer
    // Sends one character, checks both direction pins while sending and after
    // draining, and channel A's while the shifter is still busy after the FIFO emptied.
    task automatic burst(input logic ta, input logic tb2, input logic ra,
        input logic rb);
        int n;
        @(negedge core_clk);
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        repeat (4) @(negedge core_clk);
        chk1("rts a send", ta, ao.rts_n);
        chk1("rts b send", tb2, bo.rts_n);
        for (n = 0; n < 40 && !ci.tx_fifo_empty; n++) begin
            @(negedge core_clk);
        end
        if (!ci.tx_fifo_empty) begin
            err_count++;
            test_done();
        end
        repeat (3) @(negedge core_clk);
        chk1("rts a shift busy", ta, ao.rts_n);
        repeat (3) @(negedge core_clk);
        chk1("rts a drained", ra, ao.rts_n);
        chk1("rts b drained", rb, bo.rts_n);
    endtask : burst
    task automatic strap_scn;
        chk1("style", 1'b1, sty_q);
        chk1("auto strap", 1'b0, auto_q);
        chk1("div4", 1'b1, ao.prescale_div4);
        chk1("rts idle", 1'b1, ao.rts_n);
        presc = 1'b1;
        hd_n = 1'b0;
        repeat (3) @(negedge core_clk);
        chk1("div4 held", 1'b1, ao.prescale_div4);
        chk1("auto held", 1'b0, auto_q);
        presc = 1'b0;
        hd_n = 1'b1;
    endtask : strap_scn
    task automatic reg_scn;
        xfer(1'b0, 2'h0, 3'h4, 8'h02);
        chk1("oe write", 1'b0, oe_seen);
        chk1("rts a manual", 1'b0, ao.rts_n);
        chk1("rts b manual", 1'b1, bo.rts_n);
        chk1("div4 a mcr", 1'b0, ao.prescale_div4);
        chk1("div4 b strap", 1'b1, bo.prescale_div4);
        xfer(1'b0, 2'h2, 3'h5, 8'h40);
        chk1("8x a", 1'b1, ao.sample_8x);
        chk1("8x b", 1'b1, bo.sample_8x);
        xfer(1'b1, 2'h1, 3'h5, 8'h00);
        chk("feature_control_reg b", 8'h40, q);
        chk1("oe read", 1'b1, oe_seen);
        chk1("oe released", 1'b0, oe);
        xfer(1'b1, 2'h0, 3'h0, 8'h00);
        chk("unmapped", 8'h00, q);
        xfer(1'b1, 2'h2, 3'h4, 8'h00);
        chk("both read", 8'h00, q);
    endtask : reg_scn
    task automatic auto_scn;
        xfer(1'b0, 2'h0, 3'h5, 8'h08);
        chk1("rts a auto rx", 1'b1, ao.rts_n);
        burst(1'b0, 1'b1, 1'b1, 1'b1);
        xfer(1'b0, 2'h0, 3'h6, 8'h08);
        chk1("rts a inverted", 1'b0, ao.rts_n);
        burst(1'b1, 1'b1, 1'b0, 1'b1);
    endtask : auto_scn
    task automatic rnw_scn;
        @(negedge core_clk);
        sty = 1'b0;
        presc = 1'b1;
        hd_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rpin = 1'b1;
        repeat (2) @(negedge core_clk);
        chk1("style rnw", 1'b0, sty_q);
        chk1("auto strap on", 1'b1, auto_q);
        chk1("div1", 1'b0, ao.prescale_div4);
        xfer(1'b0, 2'h1, 3'h5, 8'h40);
        xfer(1'b1, 2'h1, 3'h5, 8'h00);
        chk("feature_control_reg b rnw", 8'h40, q);
        chk1("oe rnw read", 1'b1, oe_seen);
        chk1("oe rnw released", 1'b0, oe);
        xfer(1'b1, 2'h0, 3'h5, 8'h00);
        chk("feature_control_reg a rnw", 8'h00, q);
        burst(1'b0, 1'b0, 1'b1, 1'b1);
    endtask : rnw_scn
    initial begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge core_clk);
        strap_scn();
        reg_scn();
        auto_scn();
        rnw_scn();
        test_done();
    end
endmodule : tb
